// *** core/mwc_top.sv ***
// Mechanism settings and wrap coordinate block with AHB-Lite registers
`default_nettype none
`include "mwc_defs.svh"
module mwc_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Values stored in the absolute sensor
  input wire logic [15:0] sens_gear_a,
  input wire logic [15:0] sens_gear_b,
  input wire logic sens_dir_cw,
  input wire logic [14:0] sens_lead,
  input wire logic [1:0] sens_lead_dec,
  input wire logic [14:0] sens_ratio,
  input wire logic [14:0] sens_wrange,
  input wire logic [13:0] sens_offrat,
  input wire logic [29:0] sens_offval,
  input wire logic sens_wrap_en,
  // Motion logic
  input wire logic [31:0] cmd_pos,
  input wire logic [2:0] op_mode,
  // Applied settings
  output logic dir_ccw_pos,
  output logic [15:0] gear_a_out,
  output logic [15:0] gear_b_out,
  output logic [14:0] lead_out,
  output logic [1:0] lead_dec_out,
  output logic [14:0] ratio_out,
  output logic [31:0] res_out,
  output logic wrap_err,
  output logic wrap_active,
  output logic [31:0] wrap_pos
);
  mwc_div_if dv ();

  logic mech_sel_q, mech_sel_d, coord_sel_q, coord_sel_d;
  logic wrap_en_q, wrap_en_d;
  logic [1:0] dir_q, dir_d, dec_q, dec_d;
  logic [15:0] ga_q, ga_d, gb_q, gb_d;
  logic [14:0] lead_q, lead_d, ratio_q, ratio_d, wr_q, wr_d;
  logic [13:0] ofr_q, ofr_d;
  logic [29:0] ofv_q, ofv_d;
  logic wr_pend_q, wr_pend_d, rd_pend_q, rd_pend_d, rd_done_q, rd_done_d;
  logic [7:0] addr_q, addr_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic take;
  logic drv_mech, drv_dir;
  logic [15:0] ga_e, gb_e;
  logic [14:0] lead_e, ratio_e, wr_e;
  logic [1:0] dec_e;
  logic dir_e, wen_e;
  logic [13:0] ofr_e;
  logic [29:0] ofv_e;
  mwc_pkg::mwc_state_t st_q, st_d;
  logic pend_q, pend_d, c1_q, c1_d, c2_q, c2_d;
  logic [31:0] res_q, res_d, pos_q, pos_d;
  mwc_pkg::mwc_word_t ws_q, ws_d, lowb_q, lowb_d, r_w;
  logic signed [`MWC_DW-1:0] diff;
  logic home_ok, err_c, act_c;
  logic dir_o_q, err_o_q, act_o_q;
  logic [15:0] ga_o_q, gb_o_q;
  logic [14:0] lead_o_q, ratio_o_q;
  logic [1:0] dec_o_q;

  // Arithmetic engine shared by all derived values
  mwc_div u_div (
    .clk(clk),
    .rst_n(rst_n),
    .dv(dv.server)
  );

  // Effective values; direction codes 2 and 3 keep sensor mechanism data
  always_comb
  begin
    drv_mech = mech_sel_q && !dir_q[1];
    drv_dir = mech_sel_q;
    ga_e = drv_mech ? ga_q : sens_gear_a;
    gb_e = drv_mech ? gb_q : sens_gear_b;
    lead_e = drv_mech ? lead_q : sens_lead;
    dec_e = drv_mech ? dec_q : sens_lead_dec;
    ratio_e = drv_mech ? ratio_q : sens_ratio;
    if (ratio_e == 15'h0000)
    begin
      ratio_e = `MWC_RATIO_ONE;
    end
    dir_e = drv_dir ? dir_q[0] : sens_dir_cw;
    wr_e = coord_sel_q ? wr_q : sens_wrange;
    ofr_e = coord_sel_q ? ofr_q : sens_offrat;
    ofv_e = coord_sel_q ? ofv_q : sens_offval;
    wen_e = coord_sel_q ? wrap_en_q : sens_wrap_en;
  end

  // Home must sit inside the offset window
  always_comb
  begin
    home_ok = !lowb_q[`MWC_DW-1] ? (lowb_q == '0) :
      ($signed(lowb_q + ws_q) > 0);
    err_c = wen_e && !(c1_q && c2_q && home_ok);
    act_c = wen_e && !err_c && mwc_pkg::is_wrap_mode(op_mode);
  end

  // AHB-Lite: writes zero-wait, reads one wait state for a fresh word
  always_comb
  begin
    take = hsel && hready && htrans[1];
    wr_pend_d = take && hwrite;
    rd_pend_d = rd_pend_q && !rd_done_q;
    rd_done_d = 1'b0;
    addr_d = take ? haddr[7:0] : addr_q;
    hrdata_d = hrdata_q;
    if (take && !hwrite)
    begin
      rd_pend_d = 1'b1;
    end
    if (rd_pend_q && !rd_done_q)
    begin
      rd_done_d = 1'b1;
      case (addr_q)
        `MWC_OFS_CTRL: hrdata_d = {22'h000000, dec_q, 2'h0, dir_q, 1'b0,
          wrap_en_q, coord_sel_q, mech_sel_q};
        `MWC_OFS_GEAR_A: hrdata_d = {16'h0000, ga_q};
        `MWC_OFS_GEAR_B: hrdata_d = {16'h0000, gb_q};
        `MWC_OFS_LEAD: hrdata_d = {17'h00000, lead_q};
        `MWC_OFS_RATIO: hrdata_d = {17'h00000, ratio_q};
        `MWC_OFS_WRANGE: hrdata_d = {17'h00000, wr_q};
        `MWC_OFS_OFFRAT: hrdata_d = {18'h00000, ofr_q};
        `MWC_OFS_OFFVAL: hrdata_d = {{2{ofv_q[29]}}, ofv_q};
        `MWC_OFS_STATUS: hrdata_d = {26'h0000000, !dir_e, act_c, home_ok,
          c2_q, c1_q, err_c};
        `MWC_OFS_RES: hrdata_d = res_q;
        `MWC_OFS_WSTEPS: hrdata_d = ws_q[31:0];
        `MWC_OFS_WPOS: hrdata_d = pos_q;
        default: hrdata_d = 32'h00000000;
      endcase
    end
  end

  // Register writes; out-of-range values are dropped, old value kept
  always_comb
  begin
    mech_sel_d = mech_sel_q;
    coord_sel_d = coord_sel_q;
    wrap_en_d = wrap_en_q;
    dir_d = dir_q;
    dec_d = dec_q;
    ga_d = ga_q;
    gb_d = gb_q;
    lead_d = lead_q;
    ratio_d = ratio_q;
    wr_d = wr_q;
    ofr_d = ofr_q;
    ofv_d = ofv_q;
    if (wr_pend_q)
    begin
      case (addr_q)
        `MWC_OFS_CTRL:
        begin
          mech_sel_d = hwdata[`MWC_CTRL_MECH_SEL];
          coord_sel_d = hwdata[`MWC_CTRL_COORD_SEL];
          wrap_en_d = hwdata[`MWC_CTRL_WRAP_EN];
          dir_d = hwdata[`MWC_CTRL_DIR_LO +: 2];
          dec_d = hwdata[`MWC_CTRL_DEC_LO +: 2];
        end
        `MWC_OFS_GEAR_A:
          if (hwdata[31:16] == 16'h0000 && hwdata[15:0] != 16'h0000)
            ga_d = hwdata[15:0];
        `MWC_OFS_GEAR_B:
          if (hwdata[31:16] == 16'h0000 && hwdata[15:0] != 16'h0000)
            gb_d = hwdata[15:0];
        `MWC_OFS_LEAD:
          if (hwdata[31:15] == 17'h00000 && hwdata[14:0] != 15'h0000)
            lead_d = hwdata[14:0];
        `MWC_OFS_RATIO:
          if (hwdata[31:15] == 17'h00000)
            ratio_d = hwdata[14:0];
        `MWC_OFS_WRANGE:
          if (hwdata[31:15] == 17'h00000 && hwdata[14:0] != 15'h0000 &&
              hwdata[14:0] <= `MWC_MAX_WRANGE)
            wr_d = hwdata[14:0];
        `MWC_OFS_OFFRAT:
          if (hwdata[31:14] == 18'h00000 &&
              hwdata[13:0] <= `MWC_MAX_OFFRAT)
            ofr_d = hwdata[13:0];
        `MWC_OFS_OFFVAL:
          if (hwdata[31:29] == 3'h0 || hwdata[31:29] == 3'h7)
            ofv_d = hwdata[29:0];
        default: ;
      endcase
    end
  end

  // Sequencer: resolution, both integer checks, window bottom, position
  always_comb
  begin
    st_d = st_q;
    pend_d = pend_q;
    c1_d = c1_q;
    c2_d = c2_q;
    res_d = res_q;
    ws_d = ws_q;
    lowb_d = lowb_q;
    pos_d = act_c ? pos_q : cmd_pos;
    dv.start = !pend_q && (st_q != mwc_pkg::MWC_ST_IDLE);
    dv.dividend = '0;
    dv.divisor = '0;
    diff = $signed({{(`MWC_DW-32){cmd_pos[31]}}, cmd_pos}) -
      $signed(lowb_q);
    r_w = dv.rem;
    if (dv.start)
    begin
      pend_d = 1'b1;
    end
    case (st_q)
      mwc_pkg::MWC_ST_IDLE: st_d = mwc_pkg::MWC_ST_RES;
      mwc_pkg::MWC_ST_RES:
      begin
        // Widen before the product so large gear values are not cut
        dv.dividend = mwc_pkg::mwc_word_t'(gb_e) *
          mwc_pkg::mwc_word_t'(`MWC_STEPS_PER_REV);
        dv.divisor = mwc_pkg::mwc_word_t'(ga_e);
        if (dv.done)
        begin
          res_d = dv.quot[31:0];
          st_d = mwc_pkg::MWC_ST_C1;
          pend_d = 1'b0;
        end
      end
      mwc_pkg::MWC_ST_C1:
      begin
        dv.dividend = mwc_pkg::mwc_word_t'(`MWC_COORD_TENTHS);
        dv.divisor = mwc_pkg::mwc_word_t'(wr_e);
        if (dv.done)
        begin
          c1_d = (dv.rem == '0) && (wr_e != 15'h0000);
          st_d = mwc_pkg::MWC_ST_C2;
          pend_d = 1'b0;
        end
      end
      mwc_pkg::MWC_ST_C2:
      begin
        dv.dividend = mwc_pkg::mwc_word_t'(wr_e) *
          mwc_pkg::mwc_word_t'(`MWC_TENTH_SCALE) * mwc_pkg::mwc_word_t'(gb_e);
        dv.divisor = mwc_pkg::mwc_word_t'(ga_e);
        if (dv.done)
        begin
          c2_d = (dv.rem == '0);
          ws_d = dv.quot;
          st_d = mwc_pkg::MWC_ST_LOW;
          pend_d = 1'b0;
        end
      end
      mwc_pkg::MWC_ST_LOW:
      begin
        dv.dividend = mwc_pkg::mwc_word_t'(ws_q * ofr_e);
        dv.divisor = mwc_pkg::mwc_word_t'(`MWC_PCT_FULL);
        if (dv.done)
        begin
          lowb_d = mwc_pkg::mwc_word_t'($signed(ofv_e)) - dv.quot;
          st_d = mwc_pkg::MWC_ST_POS;
          pend_d = 1'b0;
        end
      end
      mwc_pkg::MWC_ST_POS:
      begin
        dv.dividend = diff[`MWC_DW-1] ? mwc_pkg::mwc_word_t'(-diff) :
          mwc_pkg::mwc_word_t'(diff);
        dv.divisor = ws_q;
        if (dv.done)
        begin
          if (diff[`MWC_DW-1] && dv.rem != '0)
          begin
            r_w = ws_q - dv.rem;
          end
          if (act_c)
          begin
            pos_d = lowb_q[31:0] + r_w[31:0];
          end
          st_d = mwc_pkg::MWC_ST_RES;
          pend_d = 1'b0;
        end
      end
      default:
      begin
        st_d = mwc_pkg::MWC_ST_IDLE;
        pend_d = 1'b0;
      end
    endcase
  end

  // All state registers except the output flops
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      rd_done_q <= 1'b0;
      addr_q <= 8'h00;
      hrdata_q <= 32'h00000000;
      mech_sel_q <= 1'b0;
      coord_sel_q <= 1'b0;
      wrap_en_q <= 1'b1;
      dir_q <= `MWC_RST_DIR;
      dec_q <= `MWC_RST_DEC;
      ga_q <= `MWC_RST_GEAR;
      gb_q <= `MWC_RST_GEAR;
      lead_q <= `MWC_RST_LEAD;
      ratio_q <= `MWC_RST_RATIO;
      wr_q <= `MWC_RST_WRANGE;
      ofr_q <= `MWC_RST_OFFRAT;
      ofv_q <= `MWC_RST_OFFVAL;
      st_q <= mwc_pkg::MWC_ST_IDLE;
      pend_q <= 1'b0;
      c1_q <= 1'b0;
      c2_q <= 1'b0;
      res_q <= 32'h00000000;
      ws_q <= '0;
      lowb_q <= '0;
      pos_q <= 32'h00000000;
    end
    else
    begin
      wr_pend_q <= wr_pend_d;
      rd_pend_q <= rd_pend_d;
      rd_done_q <= rd_done_d;
      addr_q <= addr_d;
      hrdata_q <= hrdata_d;
      mech_sel_q <= mech_sel_d;
      coord_sel_q <= coord_sel_d;
      wrap_en_q <= wrap_en_d;
      dir_q <= dir_d;
      dec_q <= dec_d;
      ga_q <= ga_d;
      gb_q <= gb_d;
      lead_q <= lead_d;
      ratio_q <= ratio_d;
      wr_q <= wr_d;
      ofr_q <= ofr_d;
      ofv_q <= ofv_d;
      st_q <= st_d;
      pend_q <= pend_d;
      c1_q <= c1_d;
      c2_q <= c2_d;
      res_q <= res_d;
      ws_q <= ws_d;
      lowb_q <= lowb_d;
      pos_q <= pos_d;
    end
  end

  // Output flops so the motion logic sees glitch-free settings
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      dir_o_q <= 1'b0;
      err_o_q <= 1'b0;
      act_o_q <= 1'b0;
      ga_o_q <= `MWC_RST_GEAR;
      gb_o_q <= `MWC_RST_GEAR;
      lead_o_q <= `MWC_RST_LEAD;
      ratio_o_q <= `MWC_RATIO_ONE;
      dec_o_q <= `MWC_RST_DEC;
    end
    else
    begin
      dir_o_q <= !dir_e;
      err_o_q <= err_c;
      act_o_q <= act_c;
      ga_o_q <= ga_e;
      gb_o_q <= gb_e;
      lead_o_q <= lead_e;
      ratio_o_q <= ratio_e;
      dec_o_q <= dec_e;
    end
  end

  assign hreadyout = !(rd_pend_q && !rd_done_q);
  assign hrdata = hrdata_q;
  assign hresp = 1'b0;
  assign dir_ccw_pos = dir_o_q;
  assign gear_a_out = ga_o_q;
  assign gear_b_out = gb_o_q;
  assign lead_out = lead_o_q;
  assign lead_dec_out = dec_o_q;
  assign ratio_out = ratio_o_q;
  assign res_out = res_q;
  assign wrap_err = err_o_q;
  assign wrap_active = act_o_q;
  assign wrap_pos = pos_q;
endmodule : mwc_top
`default_nettype wire

// *** core/mwc_defs.svh ***
// Offsets, field positions, reset values and arithmetic constants
`ifndef MWC_DEFS_SVH
`define MWC_DEFS_SVH

`define MWC_DW 56
`define MWC_OFS_CTRL 8'h00
`define MWC_OFS_GEAR_A 8'h04
`define MWC_OFS_GEAR_B 8'h08
`define MWC_OFS_LEAD 8'h0C
`define MWC_OFS_RATIO 8'h10
`define MWC_OFS_WRANGE 8'h14
`define MWC_OFS_OFFRAT 8'h18
`define MWC_OFS_OFFVAL 8'h1C
`define MWC_OFS_STATUS 8'h20
`define MWC_OFS_RES 8'h24
`define MWC_OFS_WSTEPS 8'h28
`define MWC_OFS_WPOS 8'h2C

`define MWC_CTRL_MECH_SEL 0
`define MWC_CTRL_COORD_SEL 1
`define MWC_CTRL_WRAP_EN 2
`define MWC_CTRL_DIR_LO 4
`define MWC_CTRL_DEC_LO 8

`define MWC_RST_GEAR 16'h0001
`define MWC_RST_DIR 2'h1
`define MWC_RST_LEAD 15'h0001
`define MWC_RST_DEC 2'h0
`define MWC_RST_RATIO 15'h0000
`define MWC_RST_WRANGE 15'h000A
`define MWC_RST_OFFRAT 14'h1388
`define MWC_RST_OFFVAL 30'h00000000

`define MWC_MAX_LEAD 15'h7FFF
`define MWC_MAX_WRANGE 15'h4650
`define MWC_MAX_OFFRAT 14'h2710
`define MWC_RATIO_ONE 15'h0064
`define MWC_STEPS_PER_REV 11'h3E8
`define MWC_COORD_TENTHS 15'h4650
`define MWC_TENTH_SCALE 7'h64
`define MWC_PCT_FULL 14'h2710

`endif

// *** core/mwc_pkg.sv ***
// Types shared by the mechanism and wrap coordinate block
`default_nettype none
`include "mwc_defs.svh"
package mwc_pkg;

  typedef logic [`MWC_DW-1:0] mwc_word_t;

  // Operation modes seen from the motion logic
  typedef enum logic [2:0] {
    MWC_MODE_ABS = 3'h0,
    MWC_MODE_INC = 3'h1,
    MWC_MODE_WABS = 3'h2,
    MWC_MODE_WNEAR = 3'h3,
    MWC_MODE_WFWD = 3'h4,
    MWC_MODE_WREV = 3'h5,
    MWC_MODE_CONT = 3'h6
  } mwc_mode_t;

  // Arithmetic sequencer states, one-hot
  typedef enum logic [5:0] {
    MWC_ST_IDLE = 6'h01,
    MWC_ST_RES = 6'h02,
    MWC_ST_C1 = 6'h04,
    MWC_ST_C2 = 6'h08,
    MWC_ST_LOW = 6'h10,
    MWC_ST_POS = 6'h20
  } mwc_state_t;

  function automatic logic is_wrap_mode(input logic [2:0] m);
    is_wrap_mode = (m == MWC_MODE_WABS) || (m == MWC_MODE_WNEAR) ||
      (m == MWC_MODE_WFWD) || (m == MWC_MODE_WREV);
  endfunction : is_wrap_mode

endpackage : mwc_pkg
`default_nettype wire

// *** core/mwc_div_if.sv ***
// Request and answer of the shared divider
`default_nettype none
interface mwc_div_if;
  logic start;
  mwc_pkg::mwc_word_t dividend;
  mwc_pkg::mwc_word_t divisor;
  logic done;
  mwc_pkg::mwc_word_t quot;
  mwc_pkg::mwc_word_t rem;
  modport client (output start, output dividend, output divisor,
    input done, input quot, input rem);
  modport server (input start, input dividend, input divisor,
    output done, output quot, output rem);
endinterface : mwc_div_if
`default_nettype wire

// *** core/mwc_div.sv ***
// Sequential restoring divider, one quotient bit per clock
`default_nettype none
`include "mwc_defs.svh"
module mwc_div (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Divider port
  mwc_div_if.server dv
);
  logic busy_q, busy_d;
  logic done_q, done_d;
  logic [5:0] cnt_q, cnt_d;
  mwc_pkg::mwc_word_t q_q, q_d, r_q, r_d, dv_q, dv_d;
  mwc_pkg::mwc_word_t sh;

  // One shift-subtract step; a zero divisor gives all-ones quotient
  always_comb
  begin
    busy_d = busy_q;
    cnt_d = cnt_q;
    q_d = q_q;
    r_d = r_q;
    dv_d = dv_q;
    done_d = 1'b0;
    sh = {r_q[`MWC_DW-2:0], q_q[`MWC_DW-1]};
    if (!busy_q && dv.start)
    begin
      busy_d = 1'b1;
      cnt_d = 6'h00;
      q_d = dv.dividend;
      r_d = '0;
      dv_d = dv.divisor;
    end
    else if (busy_q)
    begin
      if (sh >= dv_q)
      begin
        r_d = sh - dv_q;
        q_d = {q_q[`MWC_DW-2:0], 1'b1};
      end
      else
      begin
        r_d = sh;
        q_d = {q_q[`MWC_DW-2:0], 1'b0};
      end
      cnt_d = cnt_q + 6'h01;
      if (cnt_q == 6'(`MWC_DW - 1))
      begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end
    end
  end

  // Registers only
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      cnt_q <= 6'h00;
      q_q <= '0;
      r_q <= '0;
      dv_q <= '0;
    end
    else
    begin
      busy_q <= busy_d;
      done_q <= done_d;
      cnt_q <= cnt_d;
      q_q <= q_d;
      r_q <= r_d;
      dv_q <= dv_d;
    end
  end

  assign dv.done = done_q;
  assign dv.quot = q_q;
  assign dv.rem = r_q;
endmodule : mwc_div
`default_nettype wire

// *** tb/mwc_sensor_model.sv ***
// Partner model: values stored in the motor's absolute sensor
`default_nettype none
module mwc_sensor_model (
  // Which stored set the attached mechanism carries
  input wire logic profile,
  // Stored values
  output logic [15:0] sens_gear_a,
  output logic [15:0] sens_gear_b,
  output logic sens_dir_cw,
  output logic [14:0] sens_lead,
  output logic [1:0] sens_lead_dec,
  output logic [14:0] sens_ratio,
  output logic [14:0] sens_wrange,
  output logic [13:0] sens_offrat,
  output logic [29:0] sens_offval,
  output logic sens_wrap_en
);
  timeunit 1ns;
  timeprecision 1ns;
  // Fixed factory sets; gear values never zero, so no divide hazard
  always_comb
  begin
    sens_gear_a = profile ? 16'h0002 : 16'h0001;
    sens_gear_b = profile ? 16'h0003 : 16'h0001;
    sens_dir_cw = ~profile;
    sens_lead = profile ? 15'h0014 : 15'h0005;
    sens_lead_dec = profile ? 2'h2 : 2'h1;
    sens_ratio = profile ? 15'h01F4 : 15'h0000;
    // Only listed ranges, written as tenths of a turn
    sens_wrange = profile ? 15'h01C2 : 15'h000A;
    sens_offrat = profile ? 14'h09C4 : 14'h1388;
    sens_offval = profile ? 30'h3FFFFF9C : 30'h00000000;
    sens_wrap_en = 1'b1;
  end
endmodule : mwc_sensor_model
`default_nettype wire

// *** tb/mwc_top_checker.sv ***
// Port assertions for the mechanism and wrap coordinate block
`default_nettype none
module mwc_top_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // Motion and applied values
  input wire logic [31:0] cmd_pos,
  input wire logic [2:0] op_mode,
  input wire logic [15:0] gear_a_out,
  input wire logic [15:0] gear_b_out,
  input wire logic [14:0] lead_out,
  input wire logic [14:0] ratio_out,
  input wire logic wrap_err,
  input wire logic wrap_active,
  input wire logic [31:0] wrap_pos
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic taken;
  // Address phase accepted at this edge
  assign taken = hsel && hready && htrans[1];
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  read_wait_a: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  write_nowait_a: assert property (taken && hwrite |=> hreadyout)
    else $error("write stalled");
  gear_a_nonzero_a: assert property (gear_a_out != 16'h0000)
    else $error("gear denominator zero");
  gear_b_nonzero_a: assert property (gear_b_out != 16'h0000)
    else $error("gear numerator zero");
  lead_legal_a: assert property (lead_out != 15'h0000)
    else $error("lead zero");
  ratio_one_a: assert property (ratio_out != 15'h0000)
    else $error("disabled ratio not mapped to one");
  active_no_err_a: assert property (wrap_active |-> !wrap_err)
    else $error("wrap active with error");
  mode_gate_a: assert property ((op_mode < 3'h2 || op_mode > 3'h5) |=>
    !wrap_active) else $error("wrap active in plain mode");
  follow_cmd_a: assert property (!wrap_active && !$past(wrap_active) &&
    !$past(wrap_active, 2) |-> wrap_pos == $past(cmd_pos))
    else $error("position not passed through");
  // Main scenarios
  rd_c: cover property (taken && !hwrite);
  wr_c: cover property (taken && hwrite);
  act_c: cover property ($rose(wrap_active));
  err_c: cover property (wrap_err);
endmodule : mwc_top_checker
bind mwc_top mwc_top_checker u_mwc_top_checker (.clk, .rst_n, .hsel, .htrans,
  .hwrite, .hready, .hreadyout, .hresp, .cmd_pos, .op_mode, .gear_a_out,
  .gear_b_out, .lead_out, .ratio_out, .wrap_err, .wrap_active, .wrap_pos);
`default_nettype wire

// *** tb/tb_mwc_top.sv ***
// Self-checking bench for the mechanism and wrap coordinate block
`default_nettype none
module tb_mwc_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, profile = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, cmd_pos = 32'h0, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, op_mode = 3'h0;
  logic hreadyout, hresp, sens_dir_cw, sens_wrap_en, dir_ccw_pos;
  logic wrap_err, wrap_active;
  logic [31:0] hrdata, res_out, wrap_pos, ctrl = 32'h00000014;
  logic [15:0] sens_gear_a, sens_gear_b, gear_a_out, gear_b_out;
  logic [14:0] sens_lead, sens_ratio, sens_wrange, lead_out, ratio_out;
  logic [1:0] sens_lead_dec, lead_dec_out;
  logic [13:0] sens_offrat;
  logic [29:0] sens_offval;
  longint m_a = 1, m_b = 1, m_lead = 32767, m_ratio = 0, m_w = 10, m_r = 10000;
  longint m_ov = -536870912;
  integer seed = 81, fail_count = 0, compares = 0;
  int wt [6] = '{5, 10, 45, 120, 9000, 18000};
  logic [39:0] rtab [9] = '{40'h00_00000014, 40'h04_00000001, 40'h08_00000001,
    40'h0C_00000001, 40'h10_00000000, 40'h14_0000000A, 40'h18_00001388,
    40'h1C_00000000, 40'h30_00000000};
  logic [71:0] wtab [11] = '{72'h0C_00000000_00000001,
    72'h0C_00008000_00000001, 72'h0C_00007FFF_00007FFF,
    72'h10_00008000_00000000, 72'h14_00004651_0000000A,
    72'h18_00002711_00001388, 72'h18_00002710_00002710,
    72'h1C_20000000_00000000, 72'h1C_E0000000_E0000000,
    72'h30_FFFFFFFF_00000000, 72'h00_FFFFFFFF_00000337};

  always #50 clk = ~clk;

  mwc_sensor_model u_mwc_sensor_model (.profile(profile),
    .sens_gear_a(sens_gear_a), .sens_gear_b(sens_gear_b),
    .sens_dir_cw(sens_dir_cw), .sens_lead(sens_lead),
    .sens_lead_dec(sens_lead_dec), .sens_ratio(sens_ratio),
    .sens_wrange(sens_wrange), .sens_offrat(sens_offrat),
    .sens_offval(sens_offval), .sens_wrap_en(sens_wrap_en));
  // Single slave, so its ready is the bus ready
  mwc_top u_mwc_top (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .sens_gear_a(sens_gear_a), .sens_gear_b(sens_gear_b),
    .sens_dir_cw(sens_dir_cw), .sens_lead(sens_lead),
    .sens_lead_dec(sens_lead_dec), .sens_ratio(sens_ratio),
    .sens_wrange(sens_wrange), .sens_offrat(sens_offrat),
    .sens_offval(sens_offval), .sens_wrap_en(sens_wrap_en),
    .cmd_pos(cmd_pos), .op_mode(op_mode), .dir_ccw_pos(dir_ccw_pos),
    .gear_a_out(gear_a_out), .gear_b_out(gear_b_out), .lead_out(lead_out),
    .lead_dec_out(lead_dec_out), .ratio_out(ratio_out), .res_out(res_out),
    .wrap_err(wrap_err), .wrap_active(wrap_active), .wrap_pos(wrap_pos));

  task automatic summarize;
    if (fail_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Ready is looked at just before the edge that samples it
  task automatic wait_ready(output logic [31:0] d);
    int n;
    n = 0;
    @(negedge clk);
    while (hreadyout !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 20)
    begin
      fail_count++;
      summarize();
    end
    d = hrdata;
    @(posedge clk);
  endtask : wait_ready

  task automatic bus(input logic wr, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready(d);
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready(d);
    hsel <= 1'b0;
  endtask : bus

  // Expected applied values from the bench's own copy of the settings
  task automatic check_all;
    longint a, b, w, r, ov, st, low, pos, cmd, ra;
    logic mu, cs, en, ok, act, dir;
    // Settle first, so stimulus given just before the call is seen
    repeat (700) @(posedge clk);
    @(negedge clk);
    mu = ctrl[0] && !ctrl[5];
    cs = ctrl[1];
    a = mu ? m_a : longint'(sens_gear_a);
    b = mu ? m_b : longint'(sens_gear_b);
    ra = mu ? m_ratio : longint'(sens_ratio);
    w = cs ? m_w : longint'(sens_wrange);
    r = cs ? m_r : longint'(sens_offrat);
    ov = cs ? m_ov : longint'($signed(sens_offval));
    en = cs ? ctrl[2] : sens_wrap_en;
    dir = ctrl[0] ? !ctrl[4] : !sens_dir_cw;
    st = w * 100 * b / a;
    low = ov - st * r / 10000;
    ok = 18000 % w == 0 && (w * 100 * b) % a == 0 && low <= 0 && low + st > 0;
    act = en && ok && op_mode inside {[3'h2:3'h5]};
    cmd = longint'($signed(cmd_pos));
    pos = act ? low + ((cmd - low) % st + st) % st : cmd;
    chk("gear_a", 32'(gear_a_out), 32'(a));
    chk("gear_b", 32'(gear_b_out), 32'(b));
    chk("lead", 32'(lead_out), mu ? 32'(m_lead) : 32'(sens_lead));
    chk("dec", 32'(lead_dec_out),
      mu ? 32'(ctrl[9:8]) : 32'(sens_lead_dec));
    chk("ratio", 32'(ratio_out), ra == 0 ? 32'd100 : 32'(ra));
    chk("dir", 32'(dir_ccw_pos), 32'(dir));
    chk("res", res_out, 32'(1000 * b / a));
    chk("err", 32'(wrap_err), 32'(en && !ok));
    chk("active", 32'(wrap_active), 32'(act));
    chk("wpos", wrap_pos, 32'(pos));
    bus(1'b0, 8'h20, 32'h0, rd);
    chk("status", rd & 32'h31, {26'h0, dir, act, 3'h0, en && !ok});
  endtask : check_all

  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    // Reset contents, with one unmapped place
    for (int i = 0; i < 9; i++)
    begin
      bus(1'b0, rtab[i][39:32], 32'h0, rd);
      chk("reset_reg", rd, rtab[i][31:0]);
    end
    check_all();
    // Out-of-range and unmapped writes must leave the old value; legal limits and CTRL must stick
    for (int i = 0; i < 11; i++)
    begin
      bus(1'b1, wtab[i][71:64], wtab[i][63:32], rd);
      bus(1'b0, wtab[i][71:64], 32'h0, rd);
      chk("write_back", rd, wtab[i][31:0]);
    end
    ctrl = 32'h00000337;
    m_a = 3;
    m_b = 7;
    m_ratio = 250;
    bus(1'b1, 8'h04, 32'h3, rd);
    bus(1'b1, 8'h08, 32'h7, rd);
    bus(1'b1, 8'h10, 32'hFA, rd);
    // Every direction code with the manual source chosen
    for (int c = 0; c < 4; c++)
    begin
      ctrl = 32'h00000107 | (32'(c) << 4);
      bus(1'b1, 8'h00, ctrl, rd);
      check_all();
    end
    // Random wrap setups, sources and modes
    for (int i = 0; i < 8; i++)
    begin
      m_w = wt[$unsigned($random(seed)) % 6];
      m_a = 1 + $unsigned($random(seed)) % 3;
      m_b = 1 + $unsigned($random(seed)) % 7;
      m_r = $unsigned($random(seed)) % 10001;
      m_ov = $random(seed) % 3000;
      ctrl = $random(seed) & 32'h00000337;
      bus(1'b1, 8'h04, 32'(m_a), rd);
      bus(1'b1, 8'h08, 32'(m_b), rd);
      bus(1'b1, 8'h14, 32'(m_w), rd);
      bus(1'b1, 8'h18, 32'(m_r), rd);
      bus(1'b1, 8'h1C, 32'(m_ov), rd);
      bus(1'b1, 8'h00, ctrl, rd);
      op_mode <= 3'($unsigned($random(seed)) % 7);
      cmd_pos <= $random(seed);
      profile <= 1'($random(seed));
      check_all();
    end
    summarize();
  end
endmodule : tb_mwc_top
`default_nettype wire
